// File: bounds_decoder_defs.vh
// register map and field positions for the capability bounds decoder
`ifndef BOUNDS_DECODER_DEFS_VH
`define BOUNDS_DECODER_DEFS_VH

// ==========================================================
// register offsets (byte addresses)
`define OFS_FIELDS 8'h00
`define OFS_TFIELD 8'h04
`define OFS_BFIELD 8'h08
`define OFS_ADDR_LO 8'h0C
`define OFS_ADDR_HI 8'h10
`define OFS_NADDR_LO 8'h14
`define OFS_NADDR_HI 8'h18
`define OFS_BASE_LO 8'h1C
`define OFS_BASE_HI 8'h20
`define OFS_TOP_LO 8'h24
`define OFS_TOP_HI 8'h28
`define OFS_TOP_X 8'h2C
`define OFS_STATUS 8'h30
`define NUM_WREGS 7

// ==========================================================
// field positions
`define FLD_EXP_FORMAT 0
`define FLD_EXTRA_LEN 1
`define FLD_TAG_IN 2
`define ST_MALFORMED 0
`define ST_INFINITE 1
`define ST_REPRESENTABLE 2
`define ST_TAG_OUT 3

// ==========================================================
// reset values and responses
`define WREG_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: capability_bounds_decoder.v
// capability bounds expansion, representability check and register slave
// ==========================================================
// Functional notes
// - maximum exponent is width minus mantissa plus two; exponent field 5 or 6 bits
// - flag set: exponent zero, low mantissa bits from subfields, length term L8/0
// - flag clear: exponent is max minus subfields; low bits zero; length term one
// - top two mantissa bits are base MSBs plus carry plus length term
// - address slice at exponent; boundary is base minus quarter; unsigned compares
// - top correction from address and top comparisons against boundary
// - base correction from address and base comparisons against boundary
// - bounds substitute mantissa into address, clear low bits, correct upper bits
// - at full width top keeps correction LSB only; beyond, address ignored
// - below max minus one, invert top MSB when MSB difference exceeds one
// - infinite exactly when exponent is maximum and not malformed
// - malformed cases for internal exponent format
// - malformed encoding yields zero base and zero top
// - derived capability loses its tag when source bounds are malformed
// - representable only when new address keeps same bounds, else tag cleared
// - compare only base bounds for representability
// - the top bound extra MSB is never compared
// - exponent above max minus three always passes
// - representable span leaves at least a quarter gap beyond the bounds
// - defaults are 64-bit registers with 14-bit mantissa
// - the format flag picks zero exponent or internal exponent
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// single-address bounds expansion
module bounds_expand #(
	parameter XLEN = 64,
	parameter MW = 14,
	parameter EW = (XLEN == 32) ? 5 : 6,
	parameter HW = EW / 2
) (
	input wire exponent_format_flag,
	input wire extra_length_bit,
	input wire [HW-1:0] top_exponent_subfield,
	input wire [HW-1:0] base_exponent_subfield,
	input wire [MW-3-HW:0] top_mantissa_hi,
	input wire [MW-1-HW:0] base_mantissa_hi,
	input wire [XLEN-1:0] address,
	output wire [XLEN-1:0] base,
	output wire [XLEN:0] top,
	output wire malformed,
	output wire infinite,
	output wire always_representable
);
	localparam MAXE = XLEN - MW + 2;
	localparam [9:0] MAXE_V = MAXE;
	localparam [0:0] L8EN = (XLEN == 32);
	localparam [MW-1:0] QUARTER = 1 << (MW - 2);
	localparam [9:0] MW_V = MW;

	wire ef = exponent_format_flag;
	wire [EW-1:0] ecode;
	generate
		if (XLEN == 32) begin : g_l8
			assign ecode = {extra_length_bit, top_exponent_subfield,
				base_exponent_subfield};
		end else begin : g_nol8
			assign ecode = {top_exponent_subfield, base_exponent_subfield};
		end
	endgenerate

	// ==========================================================
	// exponent and mantissas
	// ten bits hold the sign of a too-large exponent code
	wire [9:0] e_raw = ef ? 10'h000 : (MAXE_V - {{(10-EW){1'b0}}, ecode});
	wire e_neg = ~ef & e_raw[9];
	wire [9:0] e_sh = e_neg ? 10'h000 : e_raw;
	wire [HW-1:0] hw_zero = {HW{1'b0}};
	wire [MW-3:0] tm_lo = {top_mantissa_hi,
		ef ? top_exponent_subfield : hw_zero};
	wire [MW-1:0] bm = {base_mantissa_hi,
		ef ? base_exponent_subfield : hw_zero};
	// low bits are zero without the flag, so one compare covers both forms
	wire length_carry = (tm_lo < bm[MW-3:0]);
	wire length_msb_term = ef ? (L8EN & extra_length_bit) : 1'b1;
	wire [1:0] t2 = bm[MW-1:MW-2] + {1'b0, length_carry} +
		{1'b0, length_msb_term};
	wire [MW-1:0] tm = {t2, tm_lo};

	// ==========================================================
	// corrections
	wire [MW-1:0] rm = bm - QUARTER;
	wire [XLEN-1:0] a_sl = address >> e_sh;
	wire [MW-1:0] am = a_sl[MW-1:0];
	wire a_lt = (am < rm);
	wire t_lt = (tm < rm);
	wire b_lt = (bm < rm);
	wire [1:0] ct = (t_lt & ~a_lt) ? 2'h1 : ((a_lt & ~t_lt) ? 2'h3 : 2'h0);
	wire [1:0] cb = (b_lt & ~a_lt) ? 2'h1 : ((a_lt & ~b_lt) ? 2'h3 : 2'h0);

	// ==========================================================
	// assembly; shifts past the width give zero, which
	wire [9:0] sh_hi = e_sh + MW_V;
	wire [XLEN:0] up = {1'b0, address} >> sh_hi;
	wire [XLEN:0] ct_ext = {{(XLEN-1){ct[1]}}, ct};
	wire [XLEN:0] cb_ext = {{(XLEN-1){cb[1]}}, cb};
	wire [XLEN:0] top_up = up + ct_ext;
	wire [XLEN:0] base_up = up + cb_ext;
	wire [XLEN:0] t_mid = {{(XLEN+1-MW){1'b0}}, tm} << e_sh;
	wire [XLEN:0] b_mid = {{(XLEN+1-MW){1'b0}}, bm} << e_sh;
	wire [XLEN:0] top_raw = (top_up << sh_hi) | t_mid;
	wire [XLEN:0] base_w = (base_up << sh_hi) | b_mid;
	wire [XLEN-1:0] base_raw = base_w[XLEN-1:0];

	// ==========================================================
	// top MSB fix and malformed check
	wire e_below = e_neg | (e_raw < MAXE_V - 10'h001);
	wire [1:0] msb_d = top_raw[XLEN:XLEN-1] - {1'b0, base_raw[XLEN-1]};
	wire flip = e_below & (msb_d > 2'h1);
	wire [XLEN:0] top_fix = {top_raw[XLEN] ^ flip, top_raw[XLEN-1:0]};
	wire mal_msb = ((e_raw == MAXE_V) & (bm != {MW{1'b0}})) |
		((e_raw == MAXE_V - 10'h001) & bm[MW-1]);
	wire mal_lsb = e_neg | ((e_raw == 10'h000) & L8EN);
	assign malformed = ~ef & (mal_msb | mal_lsb);
	assign base = malformed ? {XLEN{1'b0}} : base_raw;
	assign top = malformed ? {(XLEN+1){1'b0}} : top_fix;
	assign infinite = ~ef & (e_raw == MAXE_V) & ~malformed;
	assign always_representable = ~e_neg &
		(e_raw > MAXE_V - 10'h003);
endmodule

// ==========================================================
// decode at two addresses and judge representability
module bounds_check #(
	parameter XLEN = 64,
	parameter MW = 14,
	parameter EW = (XLEN == 32) ? 5 : 6,
	parameter HW = EW / 2
) (
	input wire exponent_format_flag,
	input wire extra_length_bit,
	input wire [HW-1:0] top_exponent_subfield,
	input wire [HW-1:0] base_exponent_subfield,
	input wire [MW-3-HW:0] top_mantissa_hi,
	input wire [MW-1-HW:0] base_mantissa_hi,
	input wire [XLEN-1:0] address,
	input wire [XLEN-1:0] new_address,
	input wire tag_in,
	output wire [XLEN-1:0] base,
	output wire [XLEN:0] top,
	output wire malformed,
	output wire infinite,
	output wire representable,
	output wire tag_out
);
	wire [XLEN-1:0] base_new;
	wire always_ok;

	// two copies of one combinational decoder, no state
	bounds_expand #(.XLEN(XLEN), .MW(MW), .EW(EW), .HW(HW)) u_old (
		.exponent_format_flag(exponent_format_flag),
		.extra_length_bit(extra_length_bit),
		.top_exponent_subfield(top_exponent_subfield),
		.base_exponent_subfield(base_exponent_subfield),
		.top_mantissa_hi(top_mantissa_hi),
		.base_mantissa_hi(base_mantissa_hi),
		.address(address),
		.base(base),
		.top(top),
		.malformed(malformed),
		.infinite(infinite),
		.always_representable(always_ok)
	);
	bounds_expand #(.XLEN(XLEN), .MW(MW), .EW(EW), .HW(HW)) u_new (
		.exponent_format_flag(exponent_format_flag),
		.extra_length_bit(extra_length_bit),
		.top_exponent_subfield(top_exponent_subfield),
		.base_exponent_subfield(base_exponent_subfield),
		.top_mantissa_hi(top_mantissa_hi),
		.base_mantissa_hi(base_mantissa_hi),
		.address(new_address),
		.base(base_new),
		.top(),
		.malformed(),
		.infinite(),
		.always_representable()
	);
	// base only: cheaper, and top bit XLEN needs no compare
	assign representable = always_ok | (base == base_new);
	assign tag_out = tag_in & representable & ~malformed;
endmodule

// ==========================================================
// top: pipeline path plus register copy on AXI4-Lite
`include "bounds_decoder_defs.vh"
module capability_bounds_decoder #(
	parameter XLEN = 64,
	parameter MW = 14,
	parameter EW = (XLEN == 32) ? 5 : 6,
	parameter HW = EW / 2
) (
	input wire CLK_SYS,
	input wire RSTN,
	input wire [7:0] AWADDR,
	input wire AWVALID,
	output wire AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output wire WREADY,
	output wire [1:0] BRESP,
	output wire BVALID,
	input wire BREADY,
	input wire [7:0] ARADDR,
	input wire ARVALID,
	output wire ARREADY,
	output wire [31:0] RDATA,
	output wire [1:0] RRESP,
	output wire RVALID,
	input wire RREADY,
	input wire EXPONENT_FORMAT_FLAG,
	input wire EXTRA_LENGTH_BIT,
	input wire [HW-1:0] TOP_EXPONENT_SUBFIELD,
	input wire [HW-1:0] BASE_EXPONENT_SUBFIELD,
	input wire [MW-3-HW:0] TOP_MANTISSA_FIELD,
	input wire [MW-1-HW:0] BASE_MANTISSA_FIELD,
	input wire [XLEN-1:0] ADDRESS,
	input wire [XLEN-1:0] NEW_ADDRESS,
	input wire TAG_IN,
	output wire [XLEN-1:0] BOUND_BASE,
	output wire [XLEN:0] BOUND_TOP,
	output wire BOUNDS_MALFORMED,
	output wire BOUNDS_INFINITE,
	output wire ADDR_REPRESENTABLE,
	output wire TAG_OUT
);
	// ==========================================================
	// pipeline path, same cycle
	bounds_check #(.XLEN(XLEN), .MW(MW), .EW(EW), .HW(HW)) u_pipe (
		.exponent_format_flag(EXPONENT_FORMAT_FLAG),
		.extra_length_bit(EXTRA_LENGTH_BIT),
		.top_exponent_subfield(TOP_EXPONENT_SUBFIELD),
		.base_exponent_subfield(BASE_EXPONENT_SUBFIELD),
		.top_mantissa_hi(TOP_MANTISSA_FIELD),
		.base_mantissa_hi(BASE_MANTISSA_FIELD),
		.address(ADDRESS),
		.new_address(NEW_ADDRESS),
		.tag_in(TAG_IN),
		.base(BOUND_BASE),
		.top(BOUND_TOP),
		.malformed(BOUNDS_MALFORMED),
		.infinite(BOUNDS_INFINITE),
		.representable(ADDR_REPRESENTABLE),
		.tag_out(TAG_OUT)
	);

	// ==========================================================
	// writable registers
	reg [31:0] wreg_r [0:`NUM_WREGS-1];
	wire [63:0] raddr = {wreg_r[4], wreg_r[3]};
	wire [63:0] rnaddr = {wreg_r[6], wreg_r[5]};
	wire [XLEN-1:0] r_base;
	wire [XLEN:0] r_top;
	wire r_mal;
	wire r_inf;
	wire r_rep;
	wire r_tag;

	bounds_check #(.XLEN(XLEN), .MW(MW), .EW(EW), .HW(HW)) u_regs (
		.exponent_format_flag(wreg_r[0][`FLD_EXP_FORMAT]),
		.extra_length_bit(wreg_r[0][`FLD_EXTRA_LEN]),
		.top_exponent_subfield(wreg_r[1][HW-1:0]),
		.base_exponent_subfield(wreg_r[2][HW-1:0]),
		.top_mantissa_hi(wreg_r[1][MW-3:HW]),
		.base_mantissa_hi(wreg_r[2][MW-1:HW]),
		.address(raddr[XLEN-1:0]),
		.new_address(rnaddr[XLEN-1:0]),
		.tag_in(wreg_r[0][`FLD_TAG_IN]),
		.base(r_base),
		.top(r_top),
		.malformed(r_mal),
		.infinite(r_inf),
		.representable(r_rep),
		.tag_out(r_tag)
	);

	function [31:0] merge_bytes;
		input [31:0] old_w;
		input [31:0] new_w;
		input [3:0] strb;
		integer k;
		begin
			merge_bytes = old_w;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					merge_bytes[k*8 +: 8] = new_w[k*8 +: 8];
				end
			end
		end
	endfunction

	// index of a writable word, 7 when not writable
	function [2:0] wreg_index;
		input [7:0] a;
		begin
			if (a[1:0] == 2'h0 && a < `OFS_BASE_LO) begin
				wreg_index = a[4:2];
			end else begin
				wreg_index = 3'h7;
			end
		end
	endfunction

	// ==========================================================
	// write channel
	reg aw_held_r;
	reg w_held_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	wire [2:0] widx = wreg_index(awaddr_r);
	integer i;

	assign AWREADY = ~aw_held_r & ~bvalid_r;
	assign WREADY = ~w_held_r & ~bvalid_r;
	assign BVALID = bvalid_r;
	assign BRESP = bresp_r;

	always @(posedge CLK_SYS) begin
		if (!RSTN) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			for (i = 0; i < `NUM_WREGS; i = i + 1) begin
				wreg_r[i] <= `WREG_RESET;
			end
		end else begin
			if (AWVALID && AWREADY) begin
				aw_held_r <= 1'b1;
				awaddr_r <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_held_r <= 1'b1;
				wdata_r <= WDATA;
				wstrb_r <= WSTRB;
			end
			if (aw_held_r && w_held_r) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				if (widx != 3'h7) begin
					wreg_r[widx] <= merge_bytes(wreg_r[widx], wdata_r, wstrb_r);
					bresp_r <= `RESP_OKAY;
				end else begin
					bresp_r <= `RESP_SLVERR;
				end
			end else if (bvalid_r && BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// read channel
	reg [63:0] base64;
	reg [64:0] top65;
	reg [31:0] rd_word;
	reg rd_ok;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;

	assign ARREADY = ~rvalid_r;
	assign RVALID = rvalid_r;
	assign RDATA = rdata_r;
	assign RRESP = rresp_r;

	always @* begin
		base64 = 64'h0000_0000_0000_0000;
		base64[XLEN-1:0] = r_base;
		top65 = 65'h0_0000_0000_0000_0000;
		top65[XLEN:0] = r_top;
		rd_ok = 1'b1;
		rd_word = 32'h0000_0000;
		case (ARADDR)
			`OFS_FIELDS: rd_word = wreg_r[0];
			`OFS_TFIELD: rd_word = wreg_r[1];
			`OFS_BFIELD: rd_word = wreg_r[2];
			`OFS_ADDR_LO: rd_word = wreg_r[3];
			`OFS_ADDR_HI: rd_word = wreg_r[4];
			`OFS_NADDR_LO: rd_word = wreg_r[5];
			`OFS_NADDR_HI: rd_word = wreg_r[6];
			`OFS_BASE_LO: rd_word = base64[31:0];
			`OFS_BASE_HI: rd_word = base64[63:32];
			`OFS_TOP_LO: rd_word = top65[31:0];
			`OFS_TOP_HI: rd_word = top65[63:32];
			`OFS_TOP_X: rd_word = {31'h0000_0000, top65[XLEN]};
			`OFS_STATUS: begin
				rd_word[`ST_MALFORMED] = r_mal;
				rd_word[`ST_INFINITE] = r_inf;
				rd_word[`ST_REPRESENTABLE] = r_rep;
				rd_word[`ST_TAG_OUT] = r_tag;
			end
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge CLK_SYS) begin
		if (!RSTN) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_r && RREADY) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: capability_bounds_decoder_checker.sv
// concurrent checks on the capability bounds decoder top ports
`timescale 1ns/1ps
`default_nettype none
// ========
// checker
module capability_bounds_checker #(
	parameter XLEN = 64,
	parameter MW = 14,
	parameter HW = 3
) (
	input wire CLK_SYS,
	input wire RSTN,
	input wire AWVALID,
	input wire AWREADY,
	input wire WVALID,
	input wire WREADY,
	input wire BVALID,
	input wire ARVALID,
	input wire ARREADY,
	input wire RVALID,
	input wire EXPONENT_FORMAT_FLAG,
	input wire EXTRA_LENGTH_BIT,
	input wire [HW-1:0] TOP_EXPONENT_SUBFIELD,
	input wire [HW-1:0] BASE_EXPONENT_SUBFIELD,
	input wire [MW-1-HW:0] BASE_MANTISSA_FIELD,
	input wire [XLEN-1:0] ADDRESS,
	input wire [XLEN-1:0] NEW_ADDRESS,
	input wire TAG_IN,
	input wire [XLEN-1:0] BOUND_BASE,
	input wire [XLEN:0] BOUND_TOP,
	input wire BOUNDS_MALFORMED,
	input wire BOUNDS_INFINITE,
	input wire ADDR_REPRESENTABLE,
	input wire TAG_OUT
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	// decode outputs are combinational, so sampling at the edge is enough
	a_malf_zero: assert property (BOUNDS_MALFORMED |->
		BOUND_BASE == '0 && BOUND_TOP == '0)
		else $error("malformed bounds not zero");
	a_malf_tag: assert property (BOUNDS_MALFORMED |-> !TAG_OUT)
		else $error("tag kept on malformed source");
	a_tag_gate: assert property (TAG_OUT ==
		(TAG_IN && ADDR_REPRESENTABLE && !BOUNDS_MALFORMED))
		else $error("tag out wrong");
	a_same_addr: assert property (ADDRESS == NEW_ADDRESS |->
		ADDR_REPRESENTABLE)
		else $error("unchanged address not representable");
	a_inf_bounds: assert property (BOUNDS_INFINITE |->
		BOUND_BASE == '0 && BOUND_TOP[XLEN] && !BOUNDS_MALFORMED)
		else $error("infinite flag with finite bounds");
	a_ef_formed: assert property (EXPONENT_FORMAT_FLAG |->
		!BOUNDS_MALFORMED && !BOUNDS_INFINITE)
		else $error("zero exponent flagged malformed or infinite");
	a_ef_lowbits: assert property (EXPONENT_FORMAT_FLAG |->
		BOUND_BASE[HW-1:0] == BASE_EXPONENT_SUBFIELD &&
		BOUND_TOP[HW-1:0] == TOP_EXPONENT_SUBFIELD)
		else $error("low bounds bits not from subfields");
	a_null_cap: assert property (!EXPONENT_FORMAT_FLAG &&
		!EXTRA_LENGTH_BIT && TOP_EXPONENT_SUBFIELD == '0 &&
		BASE_EXPONENT_SUBFIELD == '0 && BASE_MANTISSA_FIELD == '0 |->
		BOUNDS_INFINITE && ADDR_REPRESENTABLE)
		else $error("maximum exponent not infinite");
	// both halves are held one cycle, then the response is registered
	a_w_resp: assert property (AWVALID && AWREADY && WVALID && WREADY
		|=> ##1 BVALID)
		else $error("write response late");
	a_bus_block: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while response pending");
	a_r_resp: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read data late");
endmodule

bind capability_bounds_decoder capability_bounds_checker #(
	.XLEN(XLEN), .MW(MW), .HW(HW)) i_capability_bounds_checker (
	.CLK_SYS(CLK_SYS), .RSTN(RSTN), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RVALID(RVALID),
	.EXPONENT_FORMAT_FLAG(EXPONENT_FORMAT_FLAG),
	.EXTRA_LENGTH_BIT(EXTRA_LENGTH_BIT),
	.TOP_EXPONENT_SUBFIELD(TOP_EXPONENT_SUBFIELD),
	.BASE_EXPONENT_SUBFIELD(BASE_EXPONENT_SUBFIELD),
	.BASE_MANTISSA_FIELD(BASE_MANTISSA_FIELD), .ADDRESS(ADDRESS),
	.NEW_ADDRESS(NEW_ADDRESS), .TAG_IN(TAG_IN), .BOUND_BASE(BOUND_BASE),
	.BOUND_TOP(BOUND_TOP), .BOUNDS_MALFORMED(BOUNDS_MALFORMED),
	.BOUNDS_INFINITE(BOUNDS_INFINITE),
	.ADDR_REPRESENTABLE(ADDR_REPRESENTABLE), .TAG_OUT(TAG_OUT));

`default_nettype wire

// File: pipeline_feeder.sv
// pipeline stage model feeding capability fields to the decoder
`timescale 1ns/1ps
`default_nettype none
// ========
// operand latch ahead of the decoder
module pipeline_feeder (
	input wire logic clk,
	input wire logic [156:0] vec,
	output logic [156:0] fields
);
	// starts cleared so the decoder never sees unknown operands
	initial fields = '0;
	always @(posedge clk) begin
		fields <= vec;
	end
endmodule
`default_nettype wire

// File: test_capability_bounds_decoder.sv
// self-checking bench for the capability bounds decoder
`timescale 1ns/1ps
`include "bounds_decoder_defs.vh"
`default_nettype none
// ========
// bench top
module test_capability_bounds_decoder;
	logic CLK_SYS = 1'b0;
	logic RSTN;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP;
	logic [63:0] BOUND_BASE;
	logic [64:0] BOUND_TOP;
	logic BOUNDS_MALFORMED, BOUNDS_INFINITE, ADDR_REPRESENTABLE, TAG_OUT;
	logic [156:0] vec, fv;
	int n_errors = 0;
	int num_checks = 0;

	always #5 CLK_SYS = ~CLK_SYS;

	pipeline_feeder i_pipeline_feeder (.clk(CLK_SYS), .vec(vec), .fields(fv));

	capability_bounds_decoder i_capability_bounds_decoder (
		.CLK_SYS(CLK_SYS), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.EXPONENT_FORMAT_FLAG(fv[156]), .EXTRA_LENGTH_BIT(fv[155]),
		.TOP_EXPONENT_SUBFIELD(fv[154:152]),
		.BASE_EXPONENT_SUBFIELD(fv[151:149]),
		.TOP_MANTISSA_FIELD(fv[148:140]), .BASE_MANTISSA_FIELD(fv[139:129]),
		.ADDRESS(fv[128:65]), .NEW_ADDRESS(fv[64:1]), .TAG_IN(fv[0]),
		.BOUND_BASE(BOUND_BASE), .BOUND_TOP(BOUND_TOP),
		.BOUNDS_MALFORMED(BOUNDS_MALFORMED), .BOUNDS_INFINITE(BOUNDS_INFINITE),
		.ADDR_REPRESENTABLE(ADDR_REPRESENTABLE), .TAG_OUT(TAG_OUT)
	);

	// ========
	// reporting
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [64:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic timeout();
		n_errors++;
		$display("wrong value handshake expected answer seen none");
		end_of_test();
	endtask

	// ========
	// register bus master, waits are bounded
	task automatic wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		logic [1:0] rs;
		n = 0;
		tb = 1'b0;
		AWADDR <= ad;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!tb) begin
			@(negedge CLK_SYS);
			ta = AWVALID && AWREADY;
			tw = WVALID && WREADY;
			tb = BVALID;
			rs = BRESP;
			@(posedge CLK_SYS);
			if (ta)
				AWVALID <= 1'b0;
			if (tw)
				WVALID <= 1'b0;
			n++;
			if (n > 40)
				timeout();
		end
		BREADY <= 1'b0;
		@(posedge CLK_SYS);
		chk("write response", 65'(rs), 65'(er));
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] rs;
		n = 0;
		tr = 1'b0;
		ARADDR <= ad;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		while (!tr) begin
			@(negedge CLK_SYS);
			ta = ARVALID && ARREADY;
			tr = RVALID;
			d = RDATA;
			rs = RRESP;
			@(posedge CLK_SYS);
			if (ta)
				ARVALID <= 1'b0;
			n++;
			if (n > 40)
				timeout();
		end
		RREADY <= 1'b0;
		@(posedge CLK_SYS);
		chk("read data", 65'(d), 65'(ed));
		chk("read response", 65'(rs), 65'(er));
	endtask

	// status compares as {tag, representable, infinite, malformed}
	task automatic pipe(input logic [27:0] f, input logic [63:0] a, na, eb,
		input logic [64:0] et, input logic [3:0] es, m);
		@(posedge CLK_SYS);
		vec <= {f, a, na, 1'b1};
		repeat (2) @(posedge CLK_SYS);
		#1;
		chk("base", 65'(BOUND_BASE), 65'(eb));
		chk("top", BOUND_TOP, et);
		chk("status", 65'({TAG_OUT, ADDR_REPRESENTABLE, BOUNDS_INFINITE,
			BOUNDS_MALFORMED} & m), 65'(es & m));
	endtask

	// ========
	// scenarios
	task automatic test_regs();
		rd(`OFS_STATUS, 32'h0000_0006, `RESP_OKAY);
		rd(`OFS_TOP_X, 32'h0000_0001, `RESP_OKAY);
		rd(`OFS_FIELDS, `WREG_RESET, `RESP_OKAY);
		wr(`OFS_FIELDS, 32'h0000_0001, `RESP_OKAY);
		wr(`OFS_BFIELD, 32'h0000_0080, `RESP_OKAY);
		rd(`OFS_FIELDS, 32'h0000_0001, `RESP_OKAY);
		rd(`OFS_BASE_LO, 32'h0000_0080, `RESP_OKAY);
		rd(`OFS_TOP_LO, 32'h0000_1000, `RESP_OKAY);
		rd(`OFS_STATUS, 32'h0000_0004, `RESP_OKAY);
		// one byte lane only, the others keep their stored value
		WSTRB <= 4'h2;
		wr(`OFS_ADDR_LO, 32'hAAAA_BBBB, `RESP_OKAY);
		WSTRB <= 4'hF;
		rd(`OFS_ADDR_LO, 32'h0000_BB00, `RESP_OKAY);
		wr(`OFS_STATUS, 32'h0000_0000, `RESP_SLVERR);
		rd(8'h34, 32'h0000_0000, `RESP_SLVERR);
		$display("register test done");
	endtask

	task automatic test_zero_exp();
		pipe({1'b1, 1'b0, 3'h3, 3'h5, 9'h008, 11'h010},
			64'h0000_0000_0001_00C0, 64'h0000_0000_0001_0FFF,
			64'h0000_0000_0001_0085, 65'h0_0000_0000_0001_1043,
			4'hC, 4'hF);
		pipe({1'b1, 1'b0, 3'h3, 3'h5, 9'h008, 11'h010},
			64'h0000_0000_0001_3100, 64'h0000_0000_0001_0000,
			64'h0000_0000_0001_4085, 65'h0_0000_0000_0001_5043,
			4'h0, 4'hF);
		$display("zero exponent test done");
	endtask

	task automatic test_internal_exp();
		pipe({1'b0, 1'b0, 3'h5, 3'h2, 9'h020, 11'h010},
			64'h0000_0100_0000_0000, 64'h0000_0100_0010_0000,
			64'h0000_0100_0002_0000, 65'h0_0000_0100_0044_0000,
			4'hC, 4'hF);
		$display("internal exponent test done");
	endtask

	task automatic test_malformed();
		pipe({1'b0, 1'b0, 3'h0, 3'h0, 9'h000, 11'h001}, 64'h0, 64'h0,
			64'h0, 65'h0, 4'h5, 4'hF);
		// negative exponent leaves the representable flag unspecified
		pipe({1'b0, 1'b0, 3'h7, 3'h7, 9'h000, 11'h000}, 64'h0, 64'h0,
			64'h0, 65'h0, 4'h1, 4'hB);
		pipe({1'b0, 1'b0, 3'h0, 3'h1, 9'h000, 11'h400}, 64'h0, 64'h0,
			64'h0, 65'h0, 4'h5, 4'hF);
		$display("malformed test done");
	endtask

	task automatic test_far_exp();
		pipe({1'b0, 1'b0, 3'h0, 3'h0, 9'h000, 11'h000},
			64'hFFFF_0000_0000_0000, 64'h0, 64'h0,
			65'h1_0000_0000_0000_0000, 4'hE, 4'hF);
		pipe({1'b0, 1'b0, 3'h0, 3'h2, 9'h000, 11'h000}, 64'h0,
			64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 65'h0_4000_0000_0000_0000,
			4'hC, 4'hF);
		$display("large exponent test done");
	endtask

	// ========
	// main sequence
	initial begin
		RSTN <= 1'b0;
		AWADDR <= 8'h00;
		AWVALID <= 1'b0;
		WDATA <= 32'h0000_0000;
		WSTRB <= 4'hF;
		WVALID <= 1'b0;
		BREADY <= 1'b0;
		ARADDR <= 8'h00;
		ARVALID <= 1'b0;
		RREADY <= 1'b0;
		vec <= '0;
		repeat (3) @(posedge CLK_SYS);
		RSTN <= 1'b1;
		@(posedge CLK_SYS);
		test_regs();
		test_zero_exp();
		test_internal_exp();
		test_malformed();
		test_far_exp();
		end_of_test();
	end
endmodule
`default_nettype wire
